// File: common/fecs_pkg.sv
// package: constants, types and rule summary for the flash command sequencer
// Functional notes
// - serial-safe lock forces download reset to normal
// - only parallel full erase clears serial-safe lock
// - data array is 1024 pages of four bytes
// - 8-bit command register write starts operation
// - address high and low select page or byte
// - 01H reads page into data bytes, normal mode
// - 02H programs data page below 0400H, pre-erased
// - 02H in program mode copies 256 scratch bytes
// - 04H compares page, command reads zero on match
// - 05H erases data page or 64-byte program page
// - 06H erases whole data or program region
// - 81H reads one data byte into first register
// - 82H programs one byte, program limit DFFFH
// - 0FH selects normal mode
// - F0H selects program-write mode
// - power-on starts in normal mode
// - erase never covers less than one page
// - erase-all takes about two milliseconds
// - program page write takes about 15 ms
// - start on write, stall core until done
// - defer interrupts, timers keep running
package fecs_pkg;
  localparam logic [7:0] CMD_PAGE_READ   = 8'h01;
  localparam logic [7:0] CMD_PAGE_PROG   = 8'h02;
  localparam logic [7:0] CMD_PAGE_CMP    = 8'h04;
  localparam logic [7:0] CMD_PAGE_ERASE  = 8'h05;
  localparam logic [7:0] CMD_ERASE_ALL   = 8'h06;
  localparam logic [7:0] CMD_BYTE_READ   = 8'h81;
  localparam logic [7:0] CMD_BYTE_PROG   = 8'h82;
  localparam logic [7:0] CMD_LEAVE_PWM   = 8'h0F;
  localparam logic [7:0] CMD_ENTER_PWM   = 8'hF0;
  // register selects on the special function register port
  localparam logic [2:0] REG_COMMAND     = 3'h0;
  localparam logic [2:0] REG_ADDR_HIGH   = 3'h1;
  localparam logic [2:0] REG_ADDR_LOW    = 3'h2;
  localparam logic [2:0] REG_DATA_ONE    = 3'h3;
  localparam logic [2:0] REG_DATA_TWO    = 3'h4;
  localparam logic [2:0] REG_DATA_THREE  = 3'h5;
  localparam logic [2:0] REG_DATA_FOUR   = 3'h6;
  localparam logic [7:0] RESET_BYTE      = 8'h00;
  localparam logic [7:0] ERASED_BYTE     = 8'hFF;
  localparam logic [7:0] CMP_FAIL        = 8'h01;
  localparam logic [15:0] DATA_PAGE_LIMIT = 16'h0400;
  localparam logic [15:0] PROG_BYTE_LIMIT = 16'hDFFF;
  localparam logic [7:0]  PROG_PAGE_LIMIT = 8'hE0;
  // typical times
  localparam int CLK_MHZ        = 200;
  localparam int MACHINE_CYC    = 12;   // clocks per machine cycle
  localparam int T_READ_PAGE_MC = 25;
  localparam int T_READ_BYTE_MC = 10;
  localparam int T_PROG_PAGE_US = 380;
  localparam int T_PROG_BYTE_US = 200;
  localparam int T_ERASE_US     = 2000;
  localparam int T_PWM_PAGE_US  = 15000;
  localparam int CYC_READ_PAGE  = T_READ_PAGE_MC * MACHINE_CYC;
  localparam int CYC_READ_BYTE  = T_READ_BYTE_MC * MACHINE_CYC;
  localparam int CYC_PROG_PAGE  = T_PROG_PAGE_US * CLK_MHZ;
  localparam int CYC_PROG_BYTE  = T_PROG_BYTE_US * CLK_MHZ;
  localparam int CYC_ERASE      = T_ERASE_US * CLK_MHZ;
  localparam int CYC_PWM_PAGE   = T_PWM_PAGE_US * CLK_MHZ;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_WAIT = 4'b0010,
    ST_COPY = 4'b0100,
    ST_DONE = 4'b1000
  } fecs_state_e;
  // one program-memory write towards the code store
  typedef struct packed {
    logic        valid;
    logic        erase;   // 1: erase range, 0: program byte
    logic [15:0] addr;
    logic [15:0] last;    // last address of an erase range
    logic [7:0]  data;
  } fecs_prog_req_s;
endpackage

// File: src/fecs_sequencer.sv
// flash data array command sequencer with program-write mode
`timescale 1ns/1ps
module fecs_sequencer #(
  parameter int CYC_READ_PAGE = fecs_pkg::CYC_READ_PAGE,
  parameter int CYC_READ_BYTE = fecs_pkg::CYC_READ_BYTE,
  parameter int CYC_PROG_PAGE = fecs_pkg::CYC_PROG_PAGE,
  parameter int CYC_PROG_BYTE = fecs_pkg::CYC_PROG_BYTE,
  parameter int CYC_ERASE     = fecs_pkg::CYC_ERASE,
  parameter int CYC_PWM_PAGE  = fecs_pkg::CYC_PWM_PAGE
) (
  // clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     reset_n,
  // special function register port
  input  wire logic                     sfr_wr,
  input  wire logic [2:0]               sfr_sel,
  input  wire logic [7:0]               sfr_wdata,
  output logic      [7:0]               sfr_rdata,
  // core control
  output logic                          core_stall,
  output logic                          irq_defer,
  // extended scratch ram read port, one cycle latency
  output logic      [7:0]               extended_scratch_ram_addr,
  input  wire logic [7:0]               extended_scratch_ram_rdata,
  // program memory writes
  output fecs_pkg::fecs_prog_req_s      prog_req,
  // reset entry and security
  input  wire logic                     program_store_strobe_n,
  input  wire logic                     reset_release,
  input  wire logic                     par_full_erase,
  input  wire logic                     serial_safe_set,
  output logic                          serial_safe_lock,
  output logic                          download_entry,
  output logic                          program_write_mode
);
  import fecs_pkg::*;

  localparam int CW = 24;

  logic [7:0]  flash_command;
  logic [7:0]  flash_page_addr_high;
  logic [7:0]  flash_page_addr_low;
  logic [7:0]  flash_data_bytes [4];
  logic [7:0]  data_mem [4096];
  fecs_state_e state;
  logic [CW-1:0] wait_cnt;
  logic [7:0]  copy_idx;
  logic        copy_phase;
  logic [7:0]  cmd_q;
  logic        cmd_ok;
  logic [CW-1:0] next_wait;
  logic [15:0] addr16;
  logic [11:0] byte_addr;
  logic [11:0] page_base;
  logic        take;

  assign addr16    = {flash_page_addr_high, flash_page_addr_low};
  assign page_base = {addr16[9:0], 2'b00};
  assign byte_addr = addr16[11:0];
  // a write is taken only when idle; a stalled core cannot issue one
  assign take = sfr_wr && (state == ST_IDLE);

  // decide whether the code is valid in the current mode and its duration
  always_comb begin
    cmd_ok    = 1'b0;
    next_wait = CW'(1);
    case (sfr_wdata)
      CMD_PAGE_READ: begin
        cmd_ok    = !program_write_mode;
        next_wait = CW'(CYC_READ_PAGE);
      end
      CMD_PAGE_PROG: begin
        cmd_ok    = program_write_mode ?
                    (flash_page_addr_high < PROG_PAGE_LIMIT) :
                    (addr16 < DATA_PAGE_LIMIT);
        next_wait = program_write_mode ? CW'(CYC_PWM_PAGE)
                                       : CW'(CYC_PROG_PAGE);
      end
      CMD_PAGE_CMP: begin
        cmd_ok    = !program_write_mode;
        next_wait = CW'(CYC_READ_PAGE);
      end
      CMD_PAGE_ERASE, CMD_ERASE_ALL: begin
        cmd_ok    = 1'b1;
        next_wait = CW'(CYC_ERASE);
      end
      CMD_BYTE_READ: begin
        cmd_ok    = !program_write_mode;
        next_wait = CW'(CYC_READ_BYTE);
      end
      CMD_BYTE_PROG: begin
        cmd_ok    = !program_write_mode ||
                    (addr16 <= PROG_BYTE_LIMIT);
        next_wait = CW'(CYC_PROG_BYTE);
      end
      CMD_LEAVE_PWM, CMD_ENTER_PWM: begin
        cmd_ok    = 1'b1;
        next_wait = CW'(1);
      end
      default: begin
        cmd_ok    = 1'b0;
        next_wait = CW'(1);
      end
    endcase
  end

  // operation state machine: start at once, count the typical time
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state      <= ST_IDLE;
      wait_cnt   <= '0;
      cmd_q      <= RESET_BYTE;
      copy_idx   <= 8'h00;
      copy_phase <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (take && sfr_sel == REG_COMMAND && cmd_ok) begin
            cmd_q    <= sfr_wdata;
            wait_cnt <= next_wait;
            copy_idx <= 8'h00;
            copy_phase <= 1'b0;
            state    <= (program_write_mode &&
                         sfr_wdata == CMD_PAGE_PROG) ? ST_COPY : ST_WAIT;
          end
        end
        ST_COPY: begin
          // scratch ram has one cycle latency: address, then write
          copy_phase <= !copy_phase;
          if (copy_phase) begin
            copy_idx <= copy_idx + 8'h01;
            if (copy_idx == 8'hFF) begin
              state <= ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          if (wait_cnt <= CW'(1)) begin
            state <= ST_DONE;
          end else begin
            wait_cnt <= wait_cnt - CW'(1);
          end
        end
        ST_DONE: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // stall and interrupt deferral are two registers with the same input; timers are untouched
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      core_stall <= 1'b0;
      irq_defer  <= 1'b0;
    end else begin
      core_stall <= (take && sfr_sel == REG_COMMAND && cmd_ok) ||
                    (state == ST_COPY) || (state == ST_WAIT);
      irq_defer  <= (take && sfr_sel == REG_COMMAND && cmd_ok) ||
                    (state == ST_COPY) || (state == ST_WAIT);
    end
  end

  // mode register, normal after reset
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      program_write_mode <= 1'b0;
    end else if (take && sfr_sel == REG_COMMAND) begin
      if (sfr_wdata == CMD_ENTER_PWM) begin
        program_write_mode <= 1'b1;
      end else if (sfr_wdata == CMD_LEAVE_PWM) begin
        program_write_mode <= 1'b0;
      end
    end
  end

  // address and data registers; held while busy since writes are not taken
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      flash_page_addr_high <= RESET_BYTE;
      flash_page_addr_low  <= RESET_BYTE;
      for (int i = 0; i < 4; i++) begin
        flash_data_bytes[i] <= RESET_BYTE;
      end
    end else if (take) begin
      case (sfr_sel)
        REG_ADDR_HIGH:  flash_page_addr_high <= sfr_wdata;
        REG_ADDR_LOW:   flash_page_addr_low  <= sfr_wdata;
        REG_DATA_ONE:   flash_data_bytes[0]  <= sfr_wdata;
        REG_DATA_TWO:   flash_data_bytes[1]  <= sfr_wdata;
        REG_DATA_THREE: flash_data_bytes[2]  <= sfr_wdata;
        REG_DATA_FOUR:  flash_data_bytes[3]  <= sfr_wdata;
        default: ;
      endcase
    end else if (state == ST_DONE && !program_write_mode) begin
      if (cmd_q == CMD_PAGE_READ) begin
        for (int i = 0; i < 4; i++) begin
          flash_data_bytes[i] <= data_mem[page_base + 12'(i)];
        end
      end else if (cmd_q == CMD_BYTE_READ) begin
        flash_data_bytes[0] <= data_mem[byte_addr];
      end
    end
  end

  // data array contents; results land when the operation completes
  always_ff @(posedge sys_clk) begin
    if (state == ST_DONE && !program_write_mode) begin
      case (cmd_q)
        CMD_PAGE_PROG: begin
          for (int i = 0; i < 4; i++) begin
            data_mem[page_base + 12'(i)] <= flash_data_bytes[i];
          end
        end
        CMD_PAGE_ERASE: begin
          // whole page only, never a partial erase
          for (int i = 0; i < 4; i++) begin
            data_mem[page_base + 12'(i)] <= ERASED_BYTE;
          end
        end
        CMD_ERASE_ALL: begin
          for (int i = 0; i < 4096; i++) begin
            data_mem[i] <= ERASED_BYTE;
          end
        end
        CMD_BYTE_PROG: data_mem[byte_addr] <= flash_data_bytes[0];
        default: ;
      endcase
    end
  end

  // command register: last code while busy, then compare result or 00H when done
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      flash_command <= RESET_BYTE;
    end else if (take && sfr_sel == REG_COMMAND && cmd_ok) begin
      flash_command <= sfr_wdata;
    end else if (state == ST_DONE && cmd_q == CMD_PAGE_CMP) begin
      flash_command <= RESET_BYTE;
      for (int i = 0; i < 4; i++) begin
        if (data_mem[page_base + 12'(i)] != flash_data_bytes[i]) begin
          flash_command <= CMP_FAIL;
        end
      end
    end else if (state == ST_DONE) begin
      flash_command <= RESET_BYTE;
    end
  end

  // program-memory requests: copied page bytes, erases and byte writes
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      prog_req  <= '0;
      extended_scratch_ram_addr <= 8'h00;
    end else begin
      prog_req.valid <= 1'b0;
      // lead copy_idx by one edge so the byte is back at the write phase
      extended_scratch_ram_addr      <= (state != ST_COPY) ? 8'h00 :
                        copy_phase ? copy_idx + 8'h01 : copy_idx;
      if (state == ST_COPY && copy_phase) begin
        prog_req.valid <= 1'b1;
        prog_req.erase <= 1'b0;
        prog_req.addr  <= {flash_page_addr_high, copy_idx};
        prog_req.data  <= extended_scratch_ram_rdata;
      end else if (state == ST_DONE && program_write_mode) begin
        prog_req.valid <= (cmd_q == CMD_PAGE_ERASE) ||
                          (cmd_q == CMD_ERASE_ALL) ||
                          (cmd_q == CMD_BYTE_PROG);
        prog_req.erase <= (cmd_q != CMD_BYTE_PROG);
        prog_req.data  <= flash_data_bytes[0];
        if (cmd_q == CMD_PAGE_ERASE) begin
          prog_req.addr <= {addr16[15:6], 6'h00};
          prog_req.last <= {addr16[15:6], 6'h3F};
        end else if (cmd_q == CMD_ERASE_ALL) begin
          prog_req.addr <= 16'h0000;
          prog_req.last <= PROG_BYTE_LIMIT;
        end else begin
          prog_req.addr <= addr16;
          prog_req.last <= addr16;
        end
      end
    end
  end

  // serial-safe lock: survives core reset, cleared only by parallel erase;
  // a set in the same cycle as the erase wins, so the part stays locked
  always_ff @(posedge sys_clk) begin
    if (serial_safe_set) begin
      serial_safe_lock <= 1'b1;
    end else if (par_full_erase) begin
      serial_safe_lock <= 1'b0;
    end
  end

  // download entry decided at reset release from the strobe level
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      download_entry <= 1'b0;
    end else if (reset_release) begin
      download_entry <= !program_store_strobe_n && !serial_safe_lock;
    end
  end

  // register read mux, registered
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      sfr_rdata <= RESET_BYTE;
    end else begin
      case (sfr_sel)
        REG_COMMAND:    sfr_rdata <= flash_command;
        REG_ADDR_HIGH:  sfr_rdata <= flash_page_addr_high;
        REG_ADDR_LOW:   sfr_rdata <= flash_page_addr_low;
        REG_DATA_ONE:   sfr_rdata <= flash_data_bytes[0];
        REG_DATA_TWO:   sfr_rdata <= flash_data_bytes[1];
        REG_DATA_THREE: sfr_rdata <= flash_data_bytes[2];
        REG_DATA_FOUR:  sfr_rdata <= flash_data_bytes[3];
        default:        sfr_rdata <= RESET_BYTE;
      endcase
    end
  end

  // checks
  property p_start_stall;
    @(posedge sys_clk) disable iff (!reset_n)
    (take && sfr_sel == REG_COMMAND && cmd_ok) |=> core_stall;
  endproperty
  a_start_stall: assert property (p_start_stall)
    else $error("stall did not follow a valid command");

  property p_defer_with_stall;
    @(posedge sys_clk) disable iff (!reset_n)
    (state == ST_COPY || state == ST_WAIT) |=> (irq_defer && core_stall);
  endproperty
  a_defer_with_stall: assert property (p_defer_with_stall)
    else $error("interrupts not deferred during an operation");

  property p_bad_code;
    @(posedge sys_clk) disable iff (!reset_n)
    (take && sfr_sel == REG_COMMAND && !cmd_ok) |=> state == ST_IDLE;
  endproperty
  a_bad_code: assert property (p_bad_code)
    else $error("undefined command started an operation");

  property p_enter_pwm;
    @(posedge sys_clk) disable iff (!reset_n)
    (take && sfr_sel == REG_COMMAND && sfr_wdata == CMD_ENTER_PWM)
      |=> program_write_mode;
  endproperty
  a_enter_pwm: assert property (p_enter_pwm)
    else $error("program-write mode not entered");

  property p_leave_pwm;
    @(posedge sys_clk) disable iff (!reset_n)
    (take && sfr_sel == REG_COMMAND && sfr_wdata == CMD_LEAVE_PWM)
      |=> !program_write_mode;
  endproperty
  a_leave_pwm: assert property (p_leave_pwm)
    else $error("normal mode not restored");

  property p_regs_stable;
    @(posedge sys_clk) disable iff (!reset_n)
    (state == ST_WAIT) |=> $stable(addr16);
  endproperty
  a_regs_stable: assert property (p_regs_stable)
    else $error("address changed while busy");

  property p_lock_blocks;
    @(posedge sys_clk) disable iff (!reset_n)
    (reset_release && serial_safe_lock) |=> !download_entry;
  endproperty
  a_lock_blocks: assert property (p_lock_blocks)
    else $error("download entered under serial-safe lock");

  property p_read_timing;
    @(posedge sys_clk) disable iff (!reset_n)
    (take && sfr_sel == REG_COMMAND && cmd_ok &&
     sfr_wdata == CMD_BYTE_READ && CYC_READ_BYTE < 900)
      |=> ##[1:1000] state == ST_DONE;
  endproperty
  a_read_timing: assert property (p_read_timing)
    else $error("byte read did not complete in time");

  c_page_read: cover property (@(posedge sys_clk)
    state == ST_DONE && cmd_q == CMD_PAGE_READ);
  c_cmp_fail: cover property (@(posedge sys_clk)
    flash_command == CMP_FAIL);
  c_copy: cover property (@(posedge sys_clk) state == ST_COPY);
endmodule

// File: verification/fecs_core_model.sv
// partner model: scratch ram behind the sequencer and program store tally
`timescale 1ns/1ps
module fecs_core_model (
  // clock
  input  wire logic                     sys_clk,
  // scratch ram read port
  input  wire logic [7:0]               extended_scratch_ram_addr,
  output logic      [7:0]               extended_scratch_ram_rdata,
  // program store writes and tallies
  input  wire fecs_pkg::fecs_prog_req_s prog_req,
  output logic      [31:0]              req_count,
  output logic      [31:0]              bad_count,
  output fecs_pkg::fecs_prog_req_s      last_req
);
  import fecs_pkg::*;

  // fixed pattern, one cycle late, so a copy slip shows as a wrong byte
  always @(posedge sys_clk) begin
    extended_scratch_ram_rdata <= extended_scratch_ram_addr ^ 8'h5A;
  end

  // tally every write pulse; a program byte off the pattern counts as bad
  initial begin
    req_count = 32'h0;
    bad_count = 32'h0;
    last_req  = '0;
    forever begin
      @(posedge sys_clk);
      if (prog_req.valid === 1'b1) begin
        req_count = req_count + 32'h1;
        last_req  = prog_req;
        if (prog_req.data !== (prog_req.addr[7:0] ^ 8'h5A)) begin
          bad_count = bad_count + 32'h1;
        end
      end
    end
  end
endmodule

// File: verification/tb_flash_ee_command_sequencer.sv
// self-checking bench for the flash command sequencer
`timescale 1ns/1ps
module tb_flash_ee_command_sequencer;
  import fecs_pkg::*;
  // short operation times keep the run small
  localparam int P_ER = 12;
  logic        sys_clk   = 1'b0;
  logic        reset_n   = 1'b0;
  logic        sfr_wr    = 1'b0;
  logic [2:0]  sfr_sel   = 3'h0;
  logic [7:0]  sfr_wdata = 8'h00;
  logic        strobe_n  = 1'b1;
  logic [2:0]  ev        = 3'h0;
  logic [7:0]  sfr_rdata;
  logic [7:0]  extended_scratch_ram_addr;
  logic [7:0]  extended_scratch_ram_rdata;
  logic        core_stall;
  logic        irq_defer;
  logic        lock;
  logic        dl_entry;
  logic        pw_mode;
  logic [31:0] req_count;
  logic [31:0] bad_count;
  logic [31:0] seed      = 32'h0000BA40;
  int          err_total = 0;
  int          n_checks  = 0;
  fecs_prog_req_s prog_req;
  fecs_prog_req_s last_req;

  always #2.5 sys_clk = ~sys_clk;

  fecs_sequencer #(.CYC_READ_PAGE(6), .CYC_READ_BYTE(4), .CYC_PROG_PAGE(8),
    .CYC_PROG_BYTE(5), .CYC_ERASE(P_ER), .CYC_PWM_PAGE(10)) u_fecs_sequencer (
    .sys_clk(sys_clk), .reset_n(reset_n), .sfr_wr(sfr_wr),
    .sfr_sel(sfr_sel), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .core_stall(core_stall), .irq_defer(irq_defer), .extended_scratch_ram_addr(extended_scratch_ram_addr),
    .extended_scratch_ram_rdata(extended_scratch_ram_rdata), .prog_req(prog_req),
    .program_store_strobe_n(strobe_n), .reset_release(ev[0]),
    .par_full_erase(ev[1]), .serial_safe_set(ev[2]),
    .serial_safe_lock(lock), .download_entry(dl_entry),
    .program_write_mode(pw_mode));

  fecs_core_model u_fecs_core_model (
    .sys_clk(sys_clk), .extended_scratch_ram_addr(extended_scratch_ram_addr), .extended_scratch_ram_rdata(extended_scratch_ram_rdata),
    .prog_req(prog_req), .req_count(req_count), .bad_count(bad_count),
    .last_req(last_req));

  // xorshift source, fixed start so failures repeat
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input string what, input logic [63:0] exp,
                     input logic [63:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    @(posedge sys_clk);
    sfr_wr    <= 1'b1;
    sfr_sel   <= s;
    sfr_wdata <= d;
    @(posedge sys_clk);
    sfr_wr    <= 1'b0;
  endtask

  // read data is registered, so wait past the select change
  task automatic rd(input logic [2:0] s, output logic [7:0] v);
    @(posedge sys_clk);
    sfr_sel <= s;
    repeat (2) @(posedge sys_clk);
    #1;
    v = sfr_rdata;
  endtask

  // counts stalled cycles; gives up early when nothing starts
  task automatic wait_done(output int busy);
    busy = 0;
    for (int i = 0; i < 2000; i++) begin
      @(posedge sys_clk);
      #1;
      chk("irq_defer", {63'h0, core_stall}, {63'h0, irq_defer});
      if (core_stall === 1'b1) busy++;
      else if (busy > 0 || i > 3) break;
    end
  endtask

  task automatic cmd(input logic [7:0] c, output int busy);
    wr(REG_COMMAND, c);
    wait_done(busy);
    // the partner model tallies a request one edge after it is launched
    @(posedge sys_clk);
    #1;
  endtask

  task automatic set_addr(input logic [15:0] a);
    wr(REG_ADDR_HIGH, a[15:8]);
    wr(REG_ADDR_LOW, a[7:0]);
  endtask

  task automatic set_data(input logic [31:0] d);
    for (int i = 0; i < 4; i++) wr(REG_DATA_ONE + 3'(i), d[8*i +: 8]);
  endtask

  task automatic get_pg(output logic [31:0] d);
    logic [7:0] v;
    for (int i = 0; i < 4; i++) begin
      rd(REG_DATA_ONE + 3'(i), v);
      d[8*i +: 8] = v;
    end
  endtask

  // pulse one of set, parallel erase, release; then let it settle
  task automatic pulse(input logic [2:0] m);
    @(posedge sys_clk);
    ev <= m;
    @(posedge sys_clk);
    ev <= 3'h0;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask

  task automatic results();
    if (err_total == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // hang guard, well above the few thousand cycles the tests need
  initial begin
    repeat (60000) @(posedge sys_clk);
    err_total++;
    results();
  end

  initial begin : main
    logic [31:0] d, d0, g, q, c0;
    logic [15:0] a;
    logic [7:0]  v;
    logic [7:0]  nop_c [3];
    int          b;
    nop_c = '{CMD_PAGE_READ, CMD_PAGE_CMP, CMD_BYTE_READ};
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    #1;
    chk("mode_reset", 64'h0, {63'h0, pw_mode});
    cmd(CMD_ERASE_ALL, b);
    chk("erase_time", 64'h1, {63'h0, b >= P_ER && b <= P_ER + 4});
    // corner pages plus two random ones in separate quarters
    for (int k = 0; k < 4; k++) begin
      q = rnd();
      d = rnd();
      a = (k == 0) ? 16'h0000 : (k == 1) ? 16'h03FF
                   : {6'h00, k[1:0] - 2'h1, q[7:0]};
      if (k == 0) d0 = d;
      set_addr(a);
      cmd(CMD_PAGE_READ, b);
      get_pg(g);
      chk("erased_page", 64'hFFFFFFFF, g);
      set_data(d);
      cmd(CMD_PAGE_PROG, b);
      set_data(32'h0);
      cmd(CMD_PAGE_READ, b);
      get_pg(g);
      chk("page_read", d, g);
      cmd(CMD_PAGE_CMP, b);
      rd(REG_COMMAND, v);
      chk("verify_ok", 64'h0, v);
      wr(REG_DATA_TWO, d[15:8] ^ 8'h01);
      cmd(CMD_PAGE_CMP, b);
      rd(REG_COMMAND, v);
      chk("verify_bad", CMP_FAIL, v);
      for (int i = 0; i < 4; i++) begin
        set_addr({a[13:0], i[1:0]});
        cmd(CMD_BYTE_READ, b);
        rd(REG_DATA_ONE, v);
        chk("byte_read", d[8*i +: 8], v);
      end
    end
    // page write at the first address past the array is refused
    set_addr(16'h0400);
    set_data(~d0);
    cmd(CMD_PAGE_PROG, b);
    set_addr(16'h0000);
    cmd(CMD_PAGE_READ, b);
    get_pg(g);
    chk("page_limit", d0, g);
    cmd(CMD_PAGE_ERASE, b);
    cmd(CMD_PAGE_READ, b);
    get_pg(g);
    chk("page_erase", 64'hFFFFFFFF, g);
    set_addr(16'h0002);
    wr(REG_DATA_ONE, 8'h3C);
    cmd(CMD_BYTE_PROG, b);
    set_addr(16'h0000);
    cmd(CMD_PAGE_READ, b);
    get_pg(g);
    chk("byte_prog", 64'hFF3CFFFF, g);
    set_data(32'h11223344);
    cmd(8'h03, b);
    chk("undef_busy", 64'h0, b);
    get_pg(g);
    chk("undef_data", 64'h11223344, g);
    // a write landing while stalled must be dropped
    wr(REG_COMMAND, CMD_PAGE_ERASE);
    wr(REG_DATA_ONE, 8'hC3);
    wait_done(b);
    rd(REG_DATA_ONE, v);
    chk("busy_write", 64'h44, v);
    // lock survives a sequencer erase; only parallel erase frees it
    strobe_n <= 1'b0;
    pulse(3'b100);
    pulse(3'b001);
    chk("download_locked", 64'h0, {63'h0, dl_entry});
    cmd(CMD_ERASE_ALL, b);
    chk("lock_kept", 64'h1, {63'h0, lock});
    pulse(3'b010);
    pulse(3'b001);
    chk("lock_clear", 64'h0, {63'h0, lock});
    chk("download_open", 64'h1, {63'h0, dl_entry});
    cmd(CMD_ENTER_PWM, b);
    chk("mode_pwm", 64'h1, {63'h0, pw_mode});
    for (int i = 0; i < 3; i++) begin
      cmd(nop_c[i], b);
      chk("pwm_nop", 64'h0, b);
    end
    rd(REG_DATA_ONE, v);
    chk("pwm_nop_data", 64'h44, v);
    c0 = req_count;
    q = bad_count;
    set_addr(16'h1200);
    cmd(CMD_PAGE_PROG, b);
    chk("copy_time", 64'(2 * 256 + 10), 64'(b));
    chk("copy_pulses", c0 + 256, req_count);
    chk("copy_bytes", q, bad_count);
    chk("copy_last", 64'h12FF, last_req.addr);
    set_addr(16'h1285);
    cmd(CMD_PAGE_ERASE, b);
    chk("pwm_page_erase", {31'h0, 1'b1, 32'h128012BF},
        {31'h0, last_req.erase, last_req.addr, last_req.last});
    cmd(CMD_ERASE_ALL, b);
    chk("pwm_erase_all", {31'h0, 1'b1, 32'h0000DFFF},
        {31'h0, last_req.erase, last_req.addr, last_req.last});
    set_addr(16'hDFFF);
    wr(REG_DATA_ONE, 8'h96);
    cmd(CMD_BYTE_PROG, b);
    chk("pwm_byte", 64'h0DFFF96,
        {39'h0, last_req.erase, last_req.addr, last_req.data});
    c0 = req_count;
    set_addr(16'hE000);
    cmd(CMD_BYTE_PROG, b);
    chk("pwm_byte_limit", c0, req_count);
    // reset in mid-run returns to normal mode
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    #1;
    chk("mode_rereset", 64'h0, {63'h0, pw_mode});
    cmd(CMD_ENTER_PWM, b);
    cmd(CMD_LEAVE_PWM, b);
    chk("mode_normal", 64'h0, {63'h0, pw_mode});
    results();
  end
endmodule
